// ---- hdl/mode_seq_pkg.sv ----
package mode_seq_pkg;

  localparam int  CLK_MHZ          = 200;
  localparam int  T_MOCH_NS        = 200;
  localparam int  T_SNM_US         = 100;
  localparam int  T_STARTUP_US     = 1000;
  localparam int  MOCH_CYC         = (T_MOCH_NS * CLK_MHZ) / 1000;
  localparam int  SNM_CYC          = (T_SNM_US * CLK_MHZ) + 1;
  localparam int  STARTUP_CYC      = T_STARTUP_US * CLK_MHZ;
  localparam int  CNT_W            = 20;

  localparam logic [3:0] SEL_FULL  = 4'hf;
  localparam logic [3:0] SEL_LOWP1 = 4'h6;
  localparam logic [3:0] SEL_RXO   = 4'h8;
  localparam logic [3:0] SEL_SLEEP = 4'h1;

  typedef enum logic [3:0] {
    ST_OFF      = 4'h0,
    ST_BOOT     = 4'h1,
    ST_BOOT_FAILURE_MODE = 4'h2,
    ST_CHECK    = 4'h3,
    ST_RESET    = 4'h4,
    ST_STANDBY  = 4'h5,
    ST_SLEEP    = 4'h6,
    ST_RXONLY   = 4'h7,
    ST_NORMAL   = 4'h8
  } sys_mode_e;

  typedef struct packed {
    logic       write;
    logic [3:0] field;
  } mode_cmd_s;

  typedef struct packed {
    logic bat_uv;
    logic overtemp;
  } health_s;

endpackage

// ---- hdl/system_mode_machine.sv ----
`timescale 1ns/1ps
`default_nettype none
module system_mode_machine
  import mode_seq_pkg::*;
#(
  parameter int STARTUP_LIMIT = STARTUP_CYC,
  parameter int SNM_TIME      = SNM_CYC
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_b,
  input  wire mode_seq_pkg::health_s   health_raw,
  input  wire logic                    bus_dominant_raw,
  input  wire logic                    wake_pin_trig,
  input  wire logic                    wake_bus_trig,
  input  wire logic                    wake_pin_en,
  input  wire logic                    wake_bus_en,
  input  wire logic                    sleep_allowed,
  input  wire logic                    cfg_load_done,
  input  wire logic                    mem_check_ok,
  input  wire logic                    mem_check_fail,
  input  wire logic                    spi_msg_valid,
  input  wire mode_seq_pkg::mode_cmd_s mode_cmd,
  input  wire logic                    spi_sys_reset,
  input  wire logic                    limp_home_req,
  output logic [3:0]                   sys_mode,
  output logic                         direct_start_flag,
  output logic                         host_reset_n,
  output logic                         ext_supply_switch,
  output logic                         limp_home_out_n,
  output logic                         tx_enable,
  output logic                         rx_enable,
  output logic                         boot_ok_flag,
  output logic                         rouse_request,
  output logic                         rouse_source_chosen
);
  import mode_seq_pkg::*;

  sys_mode_e        state;
  sys_mode_e        next_state;
  logic [1:0]       uv_sync;
  logic [1:0]       ot_sync;
  logic [1:0]       dom_sync;
  logic             bat_uv;
  logic             overtemp;
  logic             dominant;
  logic [CNT_W-1:0] timer;
  logic             dom_at_entry;
  logic             spi_seen;
  logic             rouse_pend;
  logic             enter_boot;
  logic             enter_direct;
  logic             boot_pass;
  logic             next_direct;
  logic             next_host_rst_n;
  logic             next_ext_sw;
  logic             next_limp_n;
  logic             next_tx;
  logic             next_rx;
  logic             next_boot_ok;
  logic             next_rouse_req;

  // Modes in which the host runs and the mode field is obeyed
  function automatic logic is_op(input sys_mode_e s);
    return s == ST_STANDBY || s == ST_RXONLY || s == ST_NORMAL;
  endfunction

  // Modes that keep the external supply switched on
  function automatic logic is_powered(input sys_mode_e s);
    return s == ST_RESET || is_op(s);
  endfunction

  // Second stage only; first stage feeds nothing else
  assign bat_uv   = uv_sync[1];
  assign overtemp = ot_sync[1];
  assign dominant = dom_sync[1];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      uv_sync  <= 2'h0;
      ot_sync  <= 2'h0;
      dom_sync <= 2'h0;
    end else begin
      uv_sync  <= {uv_sync[0], health_raw.bat_uv};
      ot_sync  <= {ot_sync[0], health_raw.overtemp};
      dom_sync <= {dom_sync[0], bus_dominant_raw};
    end
  end

  wire sel_full  = mode_cmd.field == SEL_FULL;
  wire sel_lowp1 = mode_cmd.field == SEL_LOWP1;
  wire sel_rxo   = mode_cmd.field == SEL_RXO;
  wire sel_sleep = mode_cmd.write &&
                   mode_cmd.field == SEL_SLEEP;
  wire src_any   = wake_pin_en || wake_bus_en;
  wire wake_hit  = (wake_pin_trig && wake_pin_en) ||
                   (wake_bus_trig && wake_bus_en);
  wire op_mode   = is_op(state);
  wire boot_tmo  = timer >= CNT_W'(STARTUP_LIMIT);
  wire snm_up    = timer >= CNT_W'(SNM_TIME);
  wire snm_done  = snm_up || !dominant;
  wire snm_pass  = snm_up && dominant && dom_at_entry &&
                   !spi_seen;
  wire mode_ok   = sel_full || sel_lowp1 || sel_rxo;

  // Priority 1..3: undervoltage, SPI reset, overtemperature
  always_comb begin
    next_state = state;
    if (bat_uv) begin
      next_state = ST_OFF;
    end else if (spi_sys_reset && state != ST_OFF) begin
      next_state = ST_BOOT;
    end else if (overtemp && state == ST_NORMAL) begin
      next_state = ST_STANDBY;
    end else begin
      case (state)
        ST_OFF: begin
          next_state = ST_BOOT;
        end
        ST_BOOT: begin
          if (mem_check_fail || boot_tmo) begin
            next_state = ST_BOOT_FAILURE_MODE;
          end else if (cfg_load_done && mem_check_ok) begin
            next_state = ST_CHECK;
          end
        end
        ST_BOOT_FAILURE_MODE: begin
          next_state = ST_BOOT_FAILURE_MODE;
        end
        ST_CHECK: begin
          if (snm_pass) begin
            next_state = ST_NORMAL;
          end else if (snm_done || spi_seen) begin
            next_state = ST_RESET;
          end
        end
        ST_RESET: begin
          if (timer >= CNT_W'(MOCH_CYC)) begin
            next_state = ST_STANDBY;
          end
        end
        ST_SLEEP: begin
          if (rouse_pend || !src_any) begin
            next_state = ST_RESET;
          end
        end
        default: begin
          if (sel_sleep && sleep_allowed && src_any &&
              !rouse_pend) begin
            next_state = ST_SLEEP;
          end else if (sel_full && !overtemp) begin
            next_state = ST_NORMAL;
          end else if (sel_rxo) begin
            next_state = ST_RXONLY;
          end else if (sel_lowp1) begin
            next_state = ST_STANDBY;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_OFF;
      timer <= '0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        timer <= '0;
      end else if (!timer[CNT_W-1]) begin
        timer <= timer + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dom_at_entry <= 1'b0;
      spi_seen     <= 1'b0;
    end else begin
      if (state == ST_BOOT) begin
        dom_at_entry <= dominant;
      end
      // Cleared only on entry, so messages during boot still count
      if (enter_boot) begin
        spi_seen <= 1'b0;
      end else if (spi_msg_valid) begin
        spi_seen <= 1'b1;
      end
    end
  end

  // Event set wins over clearing on leaving Sleep
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rouse_pend <= 1'b0;
    end else if (wake_hit) begin
      rouse_pend <= 1'b1;
    end else if (state == ST_SLEEP && next_state != ST_SLEEP) begin
      rouse_pend <= 1'b0;
    end else if (op_mode && !wake_hit) begin
      rouse_pend <= 1'b0;
    end
  end

  assign enter_boot   = state != ST_BOOT && next_state == ST_BOOT;
  assign enter_direct = state == ST_CHECK && next_state == ST_NORMAL;
  assign boot_pass    = state == ST_BOOT && next_state == ST_CHECK;

  // Outputs decode next_state so the mode pins move with sys_mode; rouse_request follows rouse_pend and wake_hit
  assign next_direct     = enter_direct ||
                           (direct_start_flag &&
                            next_state != ST_BOOT);
  assign next_host_rst_n = is_op(next_state);
  assign next_ext_sw     = is_powered(next_state);
  // Host limp request overrides every mode
  assign next_limp_n     = !(next_state == ST_BOOT_FAILURE_MODE ||
                             limp_home_req);
  assign next_tx         = next_state == ST_NORMAL;
  assign next_rx         = next_state == ST_NORMAL ||
                           next_state == ST_RXONLY;
  // Pass flag lasts until the next boot starts
  assign next_boot_ok    = boot_pass ||
                           (boot_ok_flag &&
                            next_state != ST_BOOT);
  assign next_rouse_req  = rouse_pend || wake_hit;

  // Mode code mirrors the state register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sys_mode <= ST_OFF;
    end else begin
      sys_mode <= next_state;
    end
  end

  // Host-facing pins; reset pin held low until an operating mode
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      host_reset_n      <= 1'b0;
      ext_supply_switch <= 1'b0;
      limp_home_out_n   <= 1'b1;
    end else begin
      host_reset_n      <= next_host_rst_n;
      ext_supply_switch <= next_ext_sw;
      limp_home_out_n   <= next_limp_n;
    end
  end

  // Bus enables
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_enable <= 1'b0;
      rx_enable <= 1'b0;
    end else begin
      tx_enable <= next_tx;
      rx_enable <= next_rx;
    end
  end

  // Status flags
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      direct_start_flag <= 1'b0;
      boot_ok_flag      <= 1'b0;
    end else begin
      direct_start_flag <= next_direct;
      boot_ok_flag      <= next_boot_ok;
    end
  end

  // Wake status; source choice is one cycle late, as a plain level
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rouse_request       <= 1'b0;
      rouse_source_chosen <= 1'b0;
    end else begin
      rouse_request       <= next_rouse_req;
      rouse_source_chosen <= src_any;
    end
  end

endmodule
`default_nettype wire

// ---- verif/system_mode_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module system_mode_props
  import mode_seq_pkg::*;
#(
  parameter int STARTUP_LIMIT = 50,
  parameter int SNM_TIME      = 10
) (
  input wire logic                    clk_sys,
  input wire logic                    rst_b,
  input wire logic [3:0]              sys_mode,
  input wire mode_seq_pkg::mode_cmd_s mode_cmd,
  input wire logic                    mem_check_ok,
  input wire logic                    mem_check_fail,
  input wire logic                    direct_start_flag,
  input wire logic                    host_reset_n,
  input wire logic                    ext_supply_switch,
  input wire logic                    limp_home_out_n,
  input wire logic                    tx_enable,
  input wire logic                    rx_enable
);
  // Margin covers the two sync flops ahead of the bus level
  localparam int BOOT_MAX  = STARTUP_LIMIT + 4;
  localparam int CHECK_MAX = SNM_TIME + 8;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_boot_end;
    $rose(sys_mode == ST_BOOT) |-> ##[1:BOOT_MAX] sys_mode != ST_BOOT;
  endproperty
  a_boot_end: assert property (p_boot_end)
    else $error("boot overran");
  property p_mem_fail;
    sys_mode == ST_BOOT && mem_check_fail && !mem_check_ok
      |=> sys_mode inside {ST_BOOT, ST_BOOT_FAILURE_MODE, ST_OFF};
  endproperty
  a_mem_fail: assert property (p_mem_fail)
    else $error("bad memory led onward");
  property p_check_end;
    $rose(sys_mode == ST_CHECK) |-> ##[1:CHECK_MAX] sys_mode != ST_CHECK;
  endproperty
  a_check_end: assert property (p_check_end)
    else $error("start check overran");
  property p_flag;
    $rose(direct_start_flag) |-> sys_mode == ST_NORMAL
      && $past(sys_mode) == ST_CHECK;
  endproperty
  a_flag: assert property (p_flag)
    else $error("direct flag without direct start");
  property p_reset_pin;
    sys_mode == ST_RESET |-> !host_reset_n;
  endproperty
  a_reset_pin: assert property (p_reset_pin)
    else $error("host not held in reset");
  property p_standby;
    sys_mode == ST_STANDBY |-> ext_supply_switch && host_reset_n;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby outputs wrong");
  property p_sleep;
    sys_mode == ST_SLEEP |-> !ext_supply_switch && !tx_enable;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep outputs wrong");
  property p_rxonly;
    sys_mode == ST_RXONLY |-> rx_enable && !tx_enable;
  endproperty
  a_rxonly: assert property (p_rxonly)
    else $error("receive only outputs wrong");
  property p_normal;
    sys_mode == ST_NORMAL |-> tx_enable && rx_enable && host_reset_n;
  endproperty
  a_normal: assert property (p_normal)
    else $error("normal outputs wrong");
  property p_sleep_cmd;
    sys_mode != ST_SLEEP && !(mode_cmd.write && mode_cmd.field == SEL_SLEEP)
      |=> sys_mode != ST_SLEEP;
  endproperty
  a_sleep_cmd: assert property (p_sleep_cmd)
    else $error("sleep without sleep write");
  property p_boot_failure_mode;
    sys_mode == ST_BOOT_FAILURE_MODE |-> !host_reset_n && !limp_home_out_n;
  endproperty
  a_boot_failure_mode: assert property (p_boot_failure_mode)
    else $error("boot failure pins wrong");
endmodule
bind system_mode_machine system_mode_props #(
  .STARTUP_LIMIT(STARTUP_LIMIT), .SNM_TIME(SNM_TIME)
) system_mode_props_inst (
  .clk_sys(clk_sys), .rst_b(rst_b), .sys_mode(sys_mode),
  .mode_cmd(mode_cmd), .mem_check_ok(mem_check_ok),
  .mem_check_fail(mem_check_fail), .direct_start_flag(direct_start_flag),
  .host_reset_n(host_reset_n), .ext_supply_switch(ext_supply_switch),
  .limp_home_out_n(limp_home_out_n), .tx_enable(tx_enable),
  .rx_enable(rx_enable)
);
`default_nettype wire

// ---- verif/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model
  import mode_seq_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                cmd_go,
  input  wire logic [3:0]          cmd_field,
  output var mode_seq_pkg::mode_cmd_s mode_cmd,
  output var logic                 spi_msg_valid
);
  initial begin
    mode_cmd = '0;
    spi_msg_valid = 1'b0;
  end
  // Write is a one-cycle event; field keeps the last value written
  always @(posedge clk_sys) begin
    mode_cmd.write <= cmd_go;
    spi_msg_valid  <= cmd_go;
    if (cmd_go) begin
      mode_cmd.field <= cmd_field;
    end
  end
endmodule
`default_nettype wire

// ---- verif/system_mode_machine_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module system_mode_machine_bench;
  import mode_seq_pkg::*;
  localparam logic [3:0] FIELDS [3] = '{SEL_FULL, SEL_LOWP1, SEL_RXO};
  logic       clk_sys, rst_b, bus_dom, trig, pin_en, bus_en, ok, fail;
  logic       go, sys_rst, spi_msg, flag, hrst_n, ext_sw, limp_n, tx, rx;
  logic [3:0] field, sys_mode;
  logic       cfg_done, limp, boot_ok, rouse_req, rouse_src;
  health_s    health;
  mode_cmd_s  mode_cmd;
  int         n_fail, checks, seed, k;
  host_model host_model_inst (.clk_sys(clk_sys), .cmd_go(go),
    .cmd_field(field), .mode_cmd(mode_cmd), .spi_msg_valid(spi_msg));
  system_mode_machine #(.STARTUP_LIMIT(50), .SNM_TIME(10))
  system_mode_machine_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .health_raw(health), .bus_dominant_raw(bus_dom), .wake_pin_trig(trig),
    .wake_bus_trig(1'b0), .wake_pin_en(pin_en), .wake_bus_en(bus_en),
    .sleep_allowed(1'b1), .cfg_load_done(cfg_done), .mem_check_ok(ok),
    .mem_check_fail(fail), .spi_msg_valid(spi_msg), .mode_cmd(mode_cmd),
    .spi_sys_reset(sys_rst), .limp_home_req(limp), .sys_mode(sys_mode),
    .direct_start_flag(flag), .host_reset_n(hrst_n),
    .ext_supply_switch(ext_sw), .limp_home_out_n(limp_n), .tx_enable(tx),
    .rx_enable(rx), .boot_ok_flag(boot_ok), .rouse_request(rouse_req),
    .rouse_source_chosen(rouse_src));
  function automatic logic [3:0] want(input logic [3:0] f);
    return (f == SEL_FULL) ? ST_NORMAL : (f == SEL_RXO) ? ST_RXONLY
      : ST_STANDBY;
  endfunction
  task results();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task check(input string name, input logic [3:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  // Bounded poll; a miss ends the run rather than hanging
  task wait_mode(input logic [3:0] exp);
    for (int i = 0; i < 300 && sys_mode !== exp; i++) @(negedge clk_sys);
    check("sys_mode", sys_mode, exp);
    if (sys_mode !== exp) results();
  endtask
  task cmd(input logic [3:0] f);
    field = f;
    go = 1'b1;
    @(negedge clk_sys) go = 1'b0;
    @(negedge clk_sys);
  endtask
  // Bus level settles through the sync flops before the reset pulse
  task restart(input logic dom, msg, good);
    bus_dom = dom;
    ok = good;
    fail = !good;
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'b1;
    @(negedge clk_sys) sys_rst = 1'b0;
    if (msg) cmd(SEL_LOWP1);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    {rst_b, trig, bus_en, fail, go, sys_rst, field} = '0;
    {bus_dom, pin_en, ok} = 3'h7;
    {cfg_done, limp} = 2'h0;
    health = '0;
    seed = 49;
    n_fail = 0;
    checks = 0;
    repeat (4) @(negedge clk_sys);
    rst_b = 1'b1;
    // Boot long enough for the bus level to clear its sync flops
    repeat (4) @(negedge clk_sys);
    cfg_done = 1'b1;
    wait_mode(ST_NORMAL);
    check("boot_ok", boot_ok, 4'h1);
    check("flag", flag, 4'h1);
    check("tx", tx, 4'h1);
    $display("test direct_start done");
    for (int i = 0; i < 8; i++) begin
      k = ($random(seed) & 3) % 3;
      bus_en = $random(seed);
      cmd(FIELDS[k]);
      wait_mode(want(FIELDS[k]));
    end
    $display("test mode_select done");
    cmd(SEL_FULL);
    wait_mode(ST_NORMAL);
    health.overtemp = 1'b1;
    wait_mode(ST_STANDBY);
    limp = 1'b1;
    repeat (2) @(negedge clk_sys);
    check("limp_n", limp_n, 4'h0);
    limp = 1'b0;
    health.overtemp = 1'b0;
    $display("test overtemp_limp done");
    pin_en = 1'b1;
    cmd(SEL_SLEEP);
    wait_mode(ST_SLEEP);
    check("ext_sw", ext_sw, 4'h0);
    trig = 1'b1;
    @(negedge clk_sys) trig = 1'b0;
    wait_mode(ST_RESET);
    check("rouse_req", rouse_req, 4'h1);
    check("rouse_src", rouse_src, 4'h1);
    wait_mode(ST_STANDBY);
    check("ext_sw", ext_sw, 4'h1);
    $display("test sleep_wake done");
    restart(1'b1, 1'b1, 1'b1);
    wait_mode(ST_RESET);
    check("flag", flag, 4'h0);
    check("hrst_n", hrst_n, 4'h0);
    wait_mode(ST_STANDBY);
    $display("test spi_denies done");
    restart(1'b0, 1'b0, 1'b1);
    wait_mode(ST_RESET);
    wait_mode(ST_STANDBY);
    $display("test recessive_denies done");
    restart(1'b1, 1'b0, 1'b0);
    wait_mode(ST_BOOT_FAILURE_MODE);
    check("limp_n", limp_n, 4'h0);
    check("hrst_n", hrst_n, 4'h0);
    check("boot_ok", boot_ok, 4'h0);
    $display("test boot_fail done");
    results();
  end
endmodule
`default_nettype wire
